/* File: src/sbat_arbiter.sv */
`timescale 1ns/100ps
// Behaviour
// - external arbiter mode: request line is driven out when ownership wanted.
// - internal arbiter mode: grant line driven out to hand address bus away.
// - address-bus-busy held asserted for the whole own address tenure.
// - after acknowledge, busy driven inactive briefly, then released.
// - never take the address bus while an external master shows busy.
// - transfer start pulses when core or DMA begins an access.
// - external transfer start triggers snoop, internal access or memory support.
// - address acknowledge ends the address tenure of the current master.
// - retry during own transaction abandons it and retries later.
// - assert retry for cache coherency or to break a deadlock.
// - internal arbiter mode: data bus grant driven out to an external master.
// - data-bus-busy held for own data tenure, then driven inactive, released.
// - never take the data bus while an external master shows data busy.
module sbat_arbiter
  import sbat_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // configuration strap
  input wire logic arb_mode_strap,
  // internal masters
  input wire logic core_req,
  input wire logic dma_req,
  output logic access_granted,
  output logic access_done,
  output logic access_retried,
  output logic access_from_dma,
  // snoop and coherency inputs
  input wire sbat_decode_t ext_decode,
  input wire logic cache_conflict,
  input wire logic deadlock_hazard,
  // external tenure services
  output logic snoop_strobe,
  output logic internal_access_strobe,
  output logic mem_ctrl_strobe,
  // bus pins
  input wire sbat_pins_t pin_in,
  output sbat_pins_t pin_out,
  output sbat_pins_t pin_oe
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    SBAT_IDLE = 5'b00001,
    SBAT_REQ = 5'b00010,
    SBAT_ADDR = 5'b00100,
    SBAT_DATA = 5'b01000,
    SBAT_BACKOFF = 5'b10000
  } sbat_state_t;

  sbat_state_t state_q, state_d;
  logic mode_q;
  logic mode_valid_q;
  logic ext_owner_q, ext_owner_d;
  logic ext_data_q, ext_data_d;
  logic dma_sel_q;
  logic [3:0] backoff_q;
  logic ts_q, ts_d;
  logic retry_q;
  logic done_q, done_d;
  logic retried_q, retried_d;
  logic snoop_q, iacc_q, mctl_q;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire abb_active;
  wire dbb_active;
  wire internal_arb = (mode_q == ARB_MODE_INTERNAL);
  wire want_bus = core_req | dma_req;
  wire ext_abb = pin_in.address_bus_busy & ~abb_active;
  wire ext_dbb = pin_in.data_bus_busy & ~dbb_active;
  wire ext_ts = pin_in.transfer_start & ~ts_q;
  wire own_grant = internal_arb ? ~ext_owner_q : pin_in.bus_grant_line;
  wire own_dgrant = internal_arb ? ~ext_data_q : pin_in.data_bus_grant;
  wire take_addr = (state_q == SBAT_REQ) & own_grant & ~ext_abb;
  wire addr_ack = pin_in.address_acknowledge;
  wire addr_retry = pin_in.address_retry;
  wire take_data = own_dgrant & ~ext_dbb;
  wire data_end = pin_in.transfer_acknowledge;
  wire abb_start = take_addr;
  wire abb_end = addr_ack | addr_retry;
  wire dbb_start = (state_q == SBAT_ADDR) & addr_ack & ~addr_retry & take_data;
  wire dbb_end = (state_q == SBAT_DATA) & data_end;
  wire ext_req_in = internal_arb & pin_in.bus_request_line;
  wire grant_ext = ext_req_in & ~ext_abb & (state_q == SBAT_IDLE);

  // ---------------------------------------------------------------
  // strap latch
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_valid_q <= 1'b0;
    end else begin
      mode_valid_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_q <= arb_mode_strap;
    end
  end

  // ---------------------------------------------------------------
  // tenure state machine
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    ts_d = 1'b0;
    done_d = 1'b0;
    retried_d = 1'b0;
    case (state_q)
      SBAT_IDLE: begin
        if (want_bus && mode_valid_q && !grant_ext) begin
          state_d = SBAT_REQ;
        end
      end
      SBAT_REQ: begin
        if (take_addr) begin
          state_d = SBAT_ADDR;
          ts_d = 1'b1;
        end
      end
      SBAT_ADDR: begin
        if (addr_retry) begin
          state_d = SBAT_BACKOFF;
          retried_d = 1'b1;
        end else if (addr_ack && take_data) begin
          state_d = SBAT_DATA;
        end else if (addr_ack) begin
          state_d = SBAT_BACKOFF;
          retried_d = 1'b1;
        end
      end
      SBAT_DATA: begin
        if (data_end) begin
          state_d = SBAT_IDLE;
          done_d = 1'b1;
        end
      end
      SBAT_BACKOFF: begin
        if (backoff_q == 4'h0) begin
          state_d = SBAT_IDLE;
        end
      end
      default: begin
        state_d = SBAT_IDLE;
      end
    endcase
  end

  always_comb begin
    ext_owner_d = ext_owner_q;
    ext_data_d = ext_data_q;
    if (grant_ext) begin
      ext_owner_d = 1'b1;
      ext_data_d = 1'b1;
    end else if (ext_owner_q && addr_ack && !ext_abb && !ext_req_in) begin
      ext_owner_d = 1'b0;
    end
    if (ext_data_q && !ext_owner_q && !ext_dbb && !ext_abb) begin
      ext_data_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= SBAT_IDLE;
      ext_owner_q <= 1'b0;
      ext_data_q <= 1'b0;
      ts_q <= 1'b0;
      done_q <= 1'b0;
      retried_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ext_owner_q <= ext_owner_d;
      ext_data_q <= ext_data_d;
      ts_q <= ts_d;
      done_q <= done_d;
      retried_q <= retried_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dma_sel_q <= 1'b0;
      backoff_q <= 4'h0;
    end else begin
      if (state_q == SBAT_IDLE) begin
        dma_sel_q <= dma_req & ~core_req;
      end
      if (retried_d) begin
        backoff_q <= RETRY_BACKOFF_CYCLES;
      end else if (backoff_q != 4'h0) begin
        backoff_q <= backoff_q - 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // external tenure services and retry
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      snoop_q <= 1'b0;
      iacc_q <= 1'b0;
      mctl_q <= 1'b0;
      retry_q <= 1'b0;
    end else begin
      snoop_q <= ext_ts & ext_decode.snoop_enable;
      iacc_q <= ext_ts & ext_decode.internal_hit;
      mctl_q <= ext_ts & ext_decode.mem_ctrl_hit;
      retry_q <= ext_ts & ext_decode.snoop_enable & (cache_conflict | deadlock_hazard);
    end
  end

  // ---------------------------------------------------------------
  // busy line drivers
  // ---------------------------------------------------------------
  logic abb_o, abb_e, dbb_o, dbb_e;

  sbat_tristate_release u_abb (
    .ref_clk(ref_clk),
    .reset(reset),
    .tenure_start(abb_start),
    .tenure_end(abb_end),
    .pin_out(abb_o),
    .pin_oe(abb_e),
    .active(abb_active)
  );

  sbat_tristate_release u_dbb (
    .ref_clk(ref_clk),
    .reset(reset),
    .tenure_start(dbb_start),
    .tenure_end(dbb_end),
    .pin_out(dbb_o),
    .pin_oe(dbb_e),
    .active(dbb_active)
  );

  // ---------------------------------------------------------------
  // pin outputs
  // ---------------------------------------------------------------
  wire req_drive = ~internal_arb & mode_valid_q;
  wire grant_drive = internal_arb & mode_valid_q;

  assign pin_out.bus_request_line = (state_q == SBAT_REQ);
  assign pin_oe.bus_request_line = req_drive;
  assign pin_out.bus_grant_line = ext_owner_q;
  assign pin_oe.bus_grant_line = grant_drive;
  assign pin_out.data_bus_grant = ext_data_q;
  assign pin_oe.data_bus_grant = grant_drive;
  assign pin_out.address_bus_busy = abb_o;
  assign pin_oe.address_bus_busy = abb_e;
  assign pin_out.data_bus_busy = dbb_o;
  assign pin_oe.data_bus_busy = dbb_e;
  assign pin_out.transfer_start = ts_q;
  assign pin_oe.transfer_start = ts_q;
  assign pin_out.address_retry = retry_q;
  assign pin_oe.address_retry = retry_q;
  assign pin_out.address_acknowledge = 1'b0;
  assign pin_oe.address_acknowledge = 1'b0;
  assign pin_out.transfer_acknowledge = 1'b0;
  assign pin_oe.transfer_acknowledge = 1'b0;

  assign access_granted = ts_q;
  assign access_done = done_q;
  assign access_retried = retried_q;
  assign access_from_dma = dma_sel_q;
  assign snoop_strobe = snoop_q;
  assign internal_access_strobe = iacc_q;
  assign mem_ctrl_strobe = mctl_q;

endmodule

/* File: src/sbat_pkg.sv */
package sbat_pkg;

  // ---------------------------------------------------------------
  // arbitration mode, latched at reset
  // ---------------------------------------------------------------
  localparam logic ARB_MODE_EXTERNAL = 1'b0;
  localparam logic ARB_MODE_INTERNAL = 1'b1;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int REF_CLK_MHZ = 100;
  localparam int RELEASE_TIME_NS = 10;
  localparam int RELEASE_CYCLES_RAW = (RELEASE_TIME_NS * REF_CLK_MHZ) / 1000;
  localparam int RELEASE_CYCLES = (RELEASE_CYCLES_RAW < 1) ? 1 : RELEASE_CYCLES_RAW;

  // retry back-off before a new attempt, in cycles
  localparam logic [3:0] RETRY_BACKOFF_CYCLES = 4'h4;

  // ---------------------------------------------------------------
  // pin bundles: all bus pins are active high inside the block
  // ---------------------------------------------------------------
  typedef struct packed {
    logic bus_request_line;
    logic bus_grant_line;
    logic address_bus_busy;
    logic transfer_start;
    logic address_acknowledge;
    logic address_retry;
    logic data_bus_grant;
    logic data_bus_busy;
    logic transfer_acknowledge;
  } sbat_pins_t;

  typedef struct packed {
    logic snoop_enable;
    logic internal_hit;
    logic mem_ctrl_hit;
  } sbat_decode_t;

endpackage

/* File: src/sbat_tristate_release.sv */
`timescale 1ns/100ps
// drives a busy line asserted during tenure, then inactive briefly, then releases it
module sbat_tristate_release
  import sbat_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // control
  input wire logic tenure_start,
  input wire logic tenure_end,
  // pin
  output logic pin_out,
  output logic pin_oe,
  output logic active
);

  logic active_q;
  logic releasing_q;
  logic [3:0] rel_cnt_q;
  logic rel_done;

  assign rel_done = (rel_cnt_q == 4'(RELEASE_CYCLES - 1));

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      active_q <= 1'b0;
      releasing_q <= 1'b0;
      rel_cnt_q <= 4'h0;
    end else if (active_q && tenure_end) begin
      active_q <= 1'b0;
      releasing_q <= 1'b1;
      rel_cnt_q <= 4'h0;
    end else if (tenure_start) begin
      active_q <= 1'b1;
      releasing_q <= 1'b0;
    end else if (releasing_q) begin
      if (rel_done) begin
        releasing_q <= 1'b0;
      end
      rel_cnt_q <= rel_cnt_q + 4'h1;
    end
  end

  assign pin_out = active_q;
  assign pin_oe = active_q | releasing_q;
  assign active = active_q;

endmodule

/* File: verif/sbat_arbiter_props.sv */
`timescale 1ns/100ps
module sbat_arbiter_props
  import sbat_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // inputs
  input wire logic arb_mode_strap,
  input wire logic core_req,
  input wire logic dma_req,
  input wire sbat_decode_t ext_decode,
  input wire logic cache_conflict,
  input wire logic deadlock_hazard,
  input wire sbat_pins_t pin_in,
  // outputs
  input wire logic access_granted,
  input wire logic access_done,
  input wire logic access_retried,
  input wire logic snoop_strobe,
  input wire logic internal_access_strobe,
  input wire logic mem_ctrl_strobe,
  input wire sbat_pins_t pin_out,
  input wire sbat_pins_t pin_oe
);
  logic mode_q;
  wire own_abb = pin_oe.address_bus_busy & pin_out.address_bus_busy;
  wire own_dbb = pin_oe.data_bus_busy & pin_out.data_bus_busy;
  wire own_ts = pin_oe.transfer_start & pin_out.transfer_start;
  wire ext_ts = pin_in.transfer_start & ~pin_oe.transfer_start;
  wire ext_abb = pin_in.address_bus_busy & ~pin_oe.address_bus_busy;
  wire ext_dbb = pin_in.data_bus_busy & ~pin_oe.data_bus_busy;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_q <= arb_mode_strap;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_ts_with_grant: assert property (own_ts |-> access_granted && own_abb ##1 !own_ts)
    else $error("transfer start without grant or busy");
  a_no_take_busy: assert property (own_ts |-> !$past(ext_abb))
    else $error("address bus taken while busy");
  a_abb_release: assert property (own_abb && pin_in.address_acknowledge |=>
    pin_oe.address_bus_busy && !pin_out.address_bus_busy ##1 !pin_oe.address_bus_busy)
    else $error("address busy not released");
  a_dbb_release: assert property (own_dbb && pin_in.transfer_acknowledge |=>
    access_done && pin_oe.data_bus_busy && !pin_out.data_bus_busy ##1 !pin_oe.data_bus_busy)
    else $error("data busy not released");
  a_no_data_busy: assert property ($rose(own_dbb) |-> !$past(ext_dbb))
    else $error("data bus taken while busy");
  a_req_driven: assert property (!mode_q && $rose(core_req | dma_req) |=>
    pin_oe.bus_request_line && pin_out.bus_request_line)
    else $error("request line not driven");
  a_grant_out: assert property (mode_q && $rose(pin_in.bus_request_line) && !ext_abb |=>
    pin_oe.bus_grant_line && pin_out.bus_grant_line && pin_oe.data_bus_grant
    && pin_out.data_bus_grant)
    else $error("grant not driven");
  a_retry_ends: assert property (own_abb && pin_in.address_retry |-> ##[1:3] access_retried)
    else $error("retry not abandoned");
  a_snoop_answer: assert property (ext_ts |=>
    snoop_strobe == $past(ext_decode.snoop_enable)
    && internal_access_strobe == $past(ext_decode.internal_hit)
    && mem_ctrl_strobe == $past(ext_decode.mem_ctrl_hit)
    && (pin_oe.address_retry && pin_out.address_retry) == ($past(ext_decode.snoop_enable)
    && ($past(cache_conflict) || $past(deadlock_hazard))))
    else $error("external tenure not served");
  a_line_dir: assert property (mode_q ? !pin_oe.bus_request_line
    : !pin_oe.bus_grant_line && !pin_oe.data_bus_grant)
    else $error("line direction wrong for mode");
endmodule

bind sbat_arbiter sbat_arbiter_props u_props (.ref_clk(ref_clk), .reset(reset),
  .arb_mode_strap(arb_mode_strap), .core_req(core_req), .dma_req(dma_req),
  .ext_decode(ext_decode), .cache_conflict(cache_conflict), .deadlock_hazard(deadlock_hazard),
  .pin_in(pin_in), .access_granted(access_granted), .access_done(access_done),
  .access_retried(access_retried), .snoop_strobe(snoop_strobe),
  .internal_access_strobe(internal_access_strobe), .mem_ctrl_strobe(mem_ctrl_strobe),
  .pin_out(pin_out), .pin_oe(pin_oe));

/* File: verif/sbat_far_end.sv */
`timescale 1ns/100ps
// far-side arbiter and slave; the arbiter only answers on lines the device leaves as inputs
module sbat_far_end
  import sbat_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // device pins
  input wire sbat_pins_t dev_out,
  input wire sbat_pins_t dev_oe,
  // scenario control
  input wire logic retry_en,
  input wire logic slow,
  // answers, inactive when released
  output sbat_pins_t far_q
);
  logic [2:0] ack_cnt_q;
  logic [1:0] data_cnt_q;
  wire ack_now = ack_cnt_q == 3'h1;

  always_ff @(posedge ref_clk) begin
    far_q <= '0;
    if (reset) begin
      ack_cnt_q <= 3'h0;
      data_cnt_q <= 2'h0;
    end else begin
      far_q.bus_grant_line <= dev_oe.bus_request_line & dev_out.bus_request_line;
      if (dev_oe.transfer_start & dev_out.transfer_start) begin
        ack_cnt_q <= slow ? 3'h6 : 3'h2;
      end else if (ack_cnt_q != 3'h0) begin
        ack_cnt_q <= ack_cnt_q - 3'h1;
      end
      far_q.address_acknowledge <= ack_now;
      far_q.address_retry <= ack_now & retry_en;
      far_q.data_bus_grant <= ack_now & ~retry_en & ~dev_oe.data_bus_grant;
      data_cnt_q <= (dev_oe.data_bus_busy & dev_out.data_bus_busy) ? data_cnt_q + 2'h1 : 2'h0;
      far_q.transfer_acknowledge <= data_cnt_q == 2'h2;
    end
  end
endmodule

/* File: verif/system_bus_arbitration_tenure_bench.sv */
`timescale 1ns/100ps
module system_bus_arbitration_tenure_bench
  import sbat_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic strap = 1'b0;
  logic core_req = 1'b0;
  logic dma_req = 1'b0;
  logic retry_en = 1'b0;
  logic slow = 1'b0;
  logic [1:0] haz = 2'h0;
  sbat_decode_t dec = '0;
  sbat_pins_t ext_drv = '0;
  sbat_pins_t far_pins, dut_out, dut_oe, pin_in;
  logic granted, done, retried, from_dma, snoop, int_acc, mem_acc;
  int fail_count = 0;
  int compares = 0;

  always #5 ref_clk = ~ref_clk;
  assign pin_in = (dut_out & dut_oe) | far_pins | ext_drv;

  sbat_arbiter u_dut (.ref_clk(ref_clk), .reset(reset), .arb_mode_strap(strap),
    .core_req(core_req), .dma_req(dma_req), .access_granted(granted), .access_done(done),
    .access_retried(retried), .access_from_dma(from_dma), .ext_decode(dec),
    .cache_conflict(haz[0]), .deadlock_hazard(haz[1]), .snoop_strobe(snoop),
    .internal_access_strobe(int_acc), .mem_ctrl_strobe(mem_acc), .pin_in(pin_in),
    .pin_out(dut_out), .pin_oe(dut_oe));
  sbat_far_end u_far (.ref_clk(ref_clk), .reset(reset), .dev_out(dut_out), .dev_oe(dut_oe),
    .retry_en(retry_en), .slow(slow), .far_q(far_pins));

  task chk(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %b expected %b", $time, got, exp);
    end
  endtask

  task finish_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task do_reset(input logic mode);
    @(negedge ref_clk);
    reset = 1'b1;
    strap = mode;
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask

  task wait_end(output logic dn, output logic rt);
    dn = 1'b0;
    rt = 1'b0;
    for (int i = 0; i < 80 && !dn && !rt; i++) begin
      @(negedge ref_clk);
      dn = done;
      rt = retried;
    end
  endtask

  task t_core;
    logic dn, rt;
    core_req = 1'b1;
    wait_end(dn, rt);
    core_req = 1'b0;
    chk(dn, 1'b1);
    chk(dut_oe.bus_grant_line, 1'b0);
    repeat (4) @(negedge ref_clk);
  endtask

  task t_dma_slow;
    logic dn, rt;
    slow = 1'b1;
    dma_req = 1'b1;
    wait_end(dn, rt);
    dma_req = 1'b0;
    slow = 1'b0;
    chk(dn, 1'b1);
    chk(from_dma, 1'b1);
    repeat (4) @(negedge ref_clk);
  endtask

  task t_retry;
    logic dn, rt;
    retry_en = 1'b1;
    core_req = 1'b1;
    wait_end(dn, rt);
    retry_en = 1'b0;
    chk(rt, 1'b1);
    wait_end(dn, rt);
    core_req = 1'b0;
    chk(dn, 1'b1);
    repeat (4) @(negedge ref_clk);
  endtask

  task t_busy_hold;
    logic dn, rt, seen;
    seen = 1'b0;
    ext_drv.address_bus_busy = 1'b1;
    core_req = 1'b1;
    repeat (10) begin
      @(negedge ref_clk);
      seen = seen | granted;
    end
    chk(seen, 1'b0);
    ext_drv.address_bus_busy = 1'b0;
    wait_end(dn, rt);
    core_req = 1'b0;
    chk(dn, 1'b1);
    repeat (4) @(negedge ref_clk);
  endtask

  task t_data_busy;
    logic dn, rt;
    ext_drv.data_bus_busy = 1'b1;
    core_req = 1'b1;
    wait_end(dn, rt);
    chk(rt, 1'b1);
    chk(dut_oe.data_bus_busy, 1'b0);
    ext_drv.data_bus_busy = 1'b0;
    wait_end(dn, rt);
    core_req = 1'b0;
    chk(dn, 1'b1);
    repeat (4) @(negedge ref_clk);
  endtask

  task t_snoop;
    for (int k = 0; k < 4; k++) begin
      dec = {1'b1, k[0], ~k[0]};
      haz = k[1:0];
      ext_drv.transfer_start = 1'b1;
      @(negedge ref_clk);
      ext_drv.transfer_start = 1'b0;
      chk(snoop, 1'b1);
      chk(int_acc, k[0]);
      chk(mem_acc, ~k[0]);
      chk(dut_oe.address_retry & dut_out.address_retry, k != 0);
      repeat (3) @(negedge ref_clk);
    end
    dec = '0;
    haz = 2'h0;
  endtask

  task t_internal;
    logic dn, rt;
    do_reset(ARB_MODE_INTERNAL);
    chk(dut_oe.bus_request_line, 1'b0);
    ext_drv.bus_request_line = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk(dut_oe.bus_grant_line & dut_out.bus_grant_line, 1'b1);
    chk(dut_oe.data_bus_grant & dut_out.data_bus_grant, 1'b1);
    ext_drv.bus_request_line = 1'b0;
    ext_drv.address_acknowledge = 1'b1;
    @(negedge ref_clk);
    ext_drv.address_acknowledge = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk(dut_oe.bus_grant_line & dut_out.bus_grant_line, 1'b0);
    core_req = 1'b1;
    wait_end(dn, rt);
    core_req = 1'b0;
    chk(dn, 1'b1);
    chk(dut_out.bus_grant_line, 1'b0);
    repeat (4) @(negedge ref_clk);
  endtask

  initial begin
    do_reset(ARB_MODE_EXTERNAL);
    chk(dut_oe.bus_grant_line, 1'b0);
    t_core;
    t_dma_slow;
    t_retry;
    t_busy_hold;
    t_data_busy;
    t_snoop;
    t_internal;
    finish_test;
  end

  // tests need well under a thousand cycles; allow twenty thousand
  initial begin
    #200000;
    fail_count++;
    finish_test;
  end
endmodule
